// *** dv/testbench.sv ***
// Purpose: Host end and terminal end joined; Wishbone-driven scenarios.
// Assumes: Clock enable high apart from one short freeze.
// Notes:   Bus outputs are read at the edge, before that edge's updates.
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin errorCnt++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tpp_pkg::*;
  logic             clock, nrst, wbCyc, wbStb, wbWe, wbAck, irq, loadPermit;
  logic [ADR_W-1:0] wbAdr;
  logic [SEL_W-1:0] wbSel;
  logic [DAT_W-1:0] wbDat, wbDatO;
  logic             masterResetPinN, msgStart, msgEnd, msgOk, msgBusy;
  logic             bcastTxCmd, illegalDetectEn, broadcastInvalidCfg;
  logic             ce;
  logic             useBufferB, msgActive, bcastIllegal, illegalResp;
  logic [ZN_W-1:0]  circ2Count;
  int               errorCnt, totalChecks;
  tpp_link_if tpp_link_if_i ();
  tpp_host tpp_host_i (.clock(clock), .nrst(nrst), .ce(ce),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .irq_ff(irq), .loadPermit_ff(loadPermit), .link(tpp_link_if_i));
  tpp_device tpp_device_i (.clock(clock), .nrst(nrst), .ce(ce),
    .masterResetPinN(masterResetPinN), .link(tpp_link_if_i),
    .msgStart(msgStart), .msgEnd(msgEnd), .msgOk(msgOk), .msgBusy(msgBusy),
    .bcastTxCmd(bcastTxCmd), .illegalDetectEn(illegalDetectEn),
    .broadcastInvalidCfg(broadcastInvalidCfg), .useBufferB_ff(useBufferB),
    .msgActive_ff(msgActive), .bcastIllegal_ff(bcastIllegal),
    .illegalResp_ff(illegalResp), .circ2Count_ff(circ2Count));
  tpp_sva tpp_sva_i (.clock(clock), .nrst(nrst),
    .pingpongEnable(tpp_link_if_i.pingpongEnable),
    .pingpongStopRequest(tpp_link_if_i.pingpongStopRequest),
    .softwareResetCmd(tpp_link_if_i.softwareResetCmd),
    .broadcastReceivedFlag(tpp_link_if_i.broadcastReceivedFlag),
    .pingpongAck(tpp_link_if_i.pingpongAck),
    .dataPointerSelect(tpp_link_if_i.dataPointerSelect));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", errorCnt, totalChecks);
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // One classic cycle; held until ack is sampled high
  task automatic wbx(input logic we, input logic [ADR_W-1:0] a,
                     input logic [DAT_W-1:0] d, output logic [DAT_W-1:0] q);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= we;
    wbAdr <= a;
    wbDat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (wbAck !== 1'b1) begin
      errorCnt++;
      tally_and_finish();
    end
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clock);
  endtask : wbx
  task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    logic [DAT_W-1:0] q;
    wbx(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] m,
                    input logic [DAT_W-1:0] e);
    logic [DAT_W-1:0] q;
    wbx(1'b0, a, 32'h0, q);
    `CHK(q & m, e)
  endtask : rd
  task automatic waitAck(input logic v);
    int n;
    n = 0;
    while (tpp_link_if_i.pingpongAck !== v && n < 40) begin
      @(posedge clock);
      n++;
    end
    `CHK(tpp_link_if_i.pingpongAck, v)
    if (tpp_link_if_i.pingpongAck !== v) begin
      tally_and_finish();
    end
  endtask : waitAck
  task automatic msgOpen(input logic expB);
    @(posedge clock);
    msgStart <= 1'b1;
    @(posedge clock);
    msgStart <= 1'b0;
    @(posedge clock);
    `CHK(useBufferB, expB)
    `CHK(msgActive, 1'b1)
  endtask : msgOpen
  task automatic msgClose(input logic ok, input logic busy);
    msgEnd  <= 1'b1;
    msgOk   <= ok;
    msgBusy <= busy;
    @(posedge clock);
    msgEnd <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK(msgActive, 1'b0)
  endtask : msgClose
  task automatic msg(input logic ok, input logic busy, input logic expB);
    msgOpen(expB);
    msgClose(ok, busy);
  endtask : msg
  task automatic bc(input logic e);
    @(posedge clock);
    bcastTxCmd <= 1'b1;
    @(posedge clock);
    bcastTxCmd <= 1'b0;
    @(posedge clock);
    `CHK(bcastIllegal, e)
    `CHK(illegalResp, e & illegalDetectEn)
  endtask : bc
  initial begin
    {wbCyc, wbStb, wbWe, msgStart, msgEnd, msgOk, msgBusy} = 7'h00;
    {bcastTxCmd, illegalDetectEn, broadcastInvalidCfg, nrst} = 4'h0;
    wbAdr = 8'h00;
    wbDat = 32'h0;
    wbSel = 4'hf;
    masterResetPinN = 1'b1;
    ce = 1'b1;
    errorCnt = 0;
    totalChecks = 0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    rd(ADR_CTRL, 32'hffff, 32'h0);
    rd(ADR_STAT, 32'h7, 32'h0);
    rd(8'h20, 32'hffffffff, 32'h0);
    wr(ADR_EN, 32'h4);
    illegalDetectEn <= 1'b1;
    bc(1'b1);
    rd(ADR_CTRL, 32'h200, 32'h200);
    `CHK(irq, 1'b1)
    wr(ADR_CLR, 32'h4);
    `CHK(irq, 1'b0)
    masterResetPinN <= 1'b0;
    repeat (6) @(posedge clock);
    masterResetPinN <= 1'b1;
    repeat (6) @(posedge clock);
    rd(ADR_CTRL, 32'h200, 32'h0);
    broadcastInvalidCfg <= 1'b1;
    bc(1'b0);
    rd(ADR_CTRL, 32'h200, 32'h0);
    broadcastInvalidCfg <= 1'b0;
    ce <= 1'b0;
    bc(1'b0);
    ce <= 1'b1;
    rd(ADR_CTRL, 32'h200, 32'h0);
    wr(ADR_CTRL, 32'h54);
    waitAck(1'b1);
    rd(ADR_CTRL, 32'h7fc, 32'h154);
    `CHK(circ2Count, 4'h5)
    msg(1'b1, 1'b0, 1'b0);
    `CHK(tpp_link_if_i.dataPointerSelect, 1'b1)
    msg(1'b0, 1'b0, 1'b1);
    msg(1'b1, 1'b1, 1'b1);
    `CHK(tpp_link_if_i.dataPointerSelect, 1'b1)
    msgOpen(1'b1);
    wr(ADR_CTRL, 32'h5c);
    `CHK(tpp_link_if_i.pingpongAck, 1'b1)
    msgClose(1'b1, 1'b0);
    waitAck(1'b0);
    @(posedge clock);
    `CHK(loadPermit, 1'b1)
    rd(ADR_STAT, 32'h2, 32'h2);
    wr(ADR_CTRL, 32'h15c);
    `CHK(tpp_link_if_i.pingpongAck, 1'b0)
    msg(1'b1, 1'b0, 1'b0);
    msg(1'b1, 1'b0, 1'b0);
    `CHK(tpp_link_if_i.dataPointerSelect, 1'b0)
    wr(ADR_CLR, 32'h3);
    wr(ADR_CTRL, 32'h54);
    waitAck(1'b1);
    rd(ADR_STAT, 32'h3, 32'h1);
    `CHK(loadPermit, 1'b0)
    msg(1'b1, 1'b0, 1'b0);
    wr(ADR_CTRL, 32'h50);
    waitAck(1'b0);
    msg(1'b1, 1'b0, 1'b1);
    `CHK(tpp_link_if_i.dataPointerSelect, 1'b1)
    wr(ADR_CTRL, 32'h54);
    waitAck(1'b1);
    illegalDetectEn <= 1'b0;
    bc(1'b1);
    wr(ADR_CMD, 32'h1);
    repeat (3) @(posedge clock);
    rd(ADR_CTRL, 32'h600, 32'h0);
    tally_and_finish();
  end
endmodule : testbench

// *** dv/tpp_sva.sv ***
// Purpose: Checks on the link between host end and terminal end.
// Assumes: One clock; nrst synchronous, active low.
// Notes:   Master reset is only pulsed while ack and select are low.
module tpp_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Link signals
  input wire logic pingpongEnable,
  input wire logic pingpongStopRequest,
  input wire logic softwareResetCmd,
  input wire logic broadcastReceivedFlag,
  input wire logic pingpongAck,
  input wire logic dataPointerSelect
);
  timeunit 1ns;
  timeprecision 1ps;
  import tpp_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_stop_on;
    $rose(pingpongStopRequest) && pingpongEnable;
  endsequence
  sequence s_stop_off;
    $fell(pingpongStopRequest) && pingpongEnable;
  endsequence
  property p_ack_needs_en;
    pingpongAck |-> $past(pingpongEnable);
  endproperty
  property p_ack_rise;
    $rose(pingpongAck) |-> $past(pingpongEnable) && !$past(pingpongStopRequest);
  endproperty
  property p_ack_fall;
    $fell(pingpongAck) |-> $past(pingpongStopRequest) ||
      !$past(pingpongEnable) || $past(softwareResetCmd);
  endproperty
  property p_stop_drop;
    s_stop_on |-> ##[0:20] !pingpongAck;
  endproperty
  property p_stop_resume;
    s_stop_off |-> ##[0:20] pingpongAck;
  endproperty
  property p_dps_rise;
    $rose(dataPointerSelect) |-> $past(pingpongAck) && $past(pingpongEnable);
  endproperty
  property p_swrst_clr;
    softwareResetCmd |-> ##[1:2] (!broadcastReceivedFlag && !dataPointerSelect);
  endproperty
  property p_swrst_pulse;
    softwareResetCmd |=> !softwareResetCmd;
  endproperty
  a_ack_needs_en: assert property (p_ack_needs_en)
    else $error("ack high without enable");
  a_ack_rise: assert property (p_ack_rise)
    else $error("ack rose without active ping-pong");
  a_ack_fall: assert property (p_ack_fall)
    else $error("ack fell without stop request");
  a_stop_drop: assert property (p_stop_drop)
    else $error("ack not dropped after stop");
  a_stop_resume: assert property (p_stop_resume)
    else $error("ack not raised after stop cleared");
  a_dps_rise: assert property (p_dps_rise)
    else $error("select toggled while suspended");
  a_swrst_clr: assert property (p_swrst_clr)
    else $error("software reset left flags set");
  a_swrst_pulse: assert property (p_swrst_pulse)
    else $error("software reset not a pulse");
endmodule : tpp_sva

// *** logic/tpp_device.sv ***
// Purpose: Terminal end of the transmit subaddress ping-pong handshake,
//          broadcast-received flag and buffer selection.
// Assumes: Message processing gives start/end strobes on this clock;
//          master reset arrives on a pin and is synchronised here.
//          msgOk and msgBusy are sampled together with msgEnd.
// Notes:   Handshake moves only while no message is in progress, except that clearing enable or either reset drops acknowledge at once.

// Notes on behaviour
// - Broadcast transmit command sets broadcast flag
// - Set broadcast flag means illegal command response
// - Broadcast invalid config: address 31 ignored
// - Master or software reset clears broadcast flag
// - Host never writes the acknowledge bit
// - Acknowledge meaningful only with ping-pong enabled
// - Terminal raises acknowledge when ping-pong active
// - Host raises stop request before reloading buffer
// - Terminal drops acknowledge on stop request
// - Host loads buffer only while acknowledge low
// - Stop request cleared, terminal raises acknowledge
// - Suspended: same buffer, select bit frozen
// - Mode 2 trailing-zero count, host initialised
// - Select bit picks pointer A or B
// - Select bit inverts after error-free message
module tpp_device (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic                  ce,
  // Master reset pin, active low
  input  wire logic                  masterResetPinN,
  // Link to host
  tpp_link_if.term                   link,
  // Message processing strobes
  input  wire logic                  msgStart,
  input  wire logic                  msgEnd,
  input  wire logic                  msgOk,
  input  wire logic                  msgBusy,
  input  wire logic                  bcastTxCmd,
  // Terminal configuration
  input  wire logic                  illegalDetectEn,
  input  wire logic                  broadcastInvalidCfg,
  // Buffer selection and results
  output logic                       useBufferB_ff,
  output logic                       msgActive_ff,
  output logic                       bcastIllegal_ff,
  output logic                       illegalResp_ff,
  output logic [tpp_pkg::ZN_W-1:0]   circ2Count_ff
);
  import tpp_pkg::*;

  // Master reset synchroniser
  logic [SYNC_N-1:0] mrSync_ff;
  logic [SYNC_N-1:0] nxt_mrSync;
  logic              mrLevel_ff;
  logic              nxt_mrLevel;

  // Handshake and flag state
  tpp_msg_state_t    state_ff;
  tpp_msg_state_t    nxt_state;
  logic              ack_ff;
  logic              nxt_ack;
  logic              dps_ff;
  logic              nxt_dps;
  logic              broadcast_received_flag_ff;
  logic              nxt_broadcast_received_flag;

  // User-side outputs
  logic              nxt_useB;
  logic              nxt_msgActive;
  logic              nxt_bcIllegal;
  logic              nxt_illResp;
  logic [ZN_W-1:0]   nxt_circ2;

  // Decoded terms
  logic              clrFlags;
  logic              bcastHit;
  logic              betweenMsgs;

  assign link.pingpongAck           = ack_ff;
  assign link.dataPointerSelect     = dps_ff;
  assign link.broadcastReceivedFlag = broadcast_received_flag_ff;

  // Master reset pin: three stages, a change counts once 2 and 3 agree
  // Stage 1 may go metastable, so only stage 2 ever samples it
  always_comb begin
    nxt_mrSync = {mrSync_ff[SYNC_N-2:0], masterResetPinN};
    if (mrSync_ff[SYNC_N-2] == mrSync_ff[SYNC_N-1]) begin
      nxt_mrLevel = mrSync_ff[SYNC_N-1];
    end else begin
      nxt_mrLevel = mrLevel_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      mrSync_ff  <= '1;
      mrLevel_ff <= 1'b1;
    end else if (ce) begin
      mrSync_ff  <= nxt_mrSync;
      mrLevel_ff <= nxt_mrLevel;
    end
  end

  // Message sequencing, handshake and buffer select
  always_comb begin
    // Pin reset is a level: flags stay clear while it is held low
    clrFlags    = ~mrLevel_ff | link.softwareResetCmd;
    bcastHit    = bcastTxCmd & ~broadcastInvalidCfg;
    betweenMsgs = (state_ff == TPP_IDLE) & ~msgStart;

    nxt_state     = state_ff;
    nxt_ack       = ack_ff;
    nxt_dps       = dps_ff;

    case (state_ff)
      TPP_IDLE: begin
        if (msgStart) begin
          nxt_state = TPP_MSG;
        end
      end
      TPP_MSG: begin
        if (msgEnd) begin
          nxt_state = TPP_IDLE;
          // Frozen while suspended or when the message failed
          if (link.pingpongEnable && ack_ff && msgOk && !msgBusy) begin
            nxt_dps = ~dps_ff;
          end
        end
      end
      default: begin
        nxt_state = TPP_IDLE;
      end
    endcase

    // Acknowledge follows the stop request only between messages
    if (!link.pingpongEnable) begin
      nxt_ack = 1'b0;
    end else if (betweenMsgs) begin
      nxt_ack = ~link.pingpongStopRequest;
    end

    // Either reset returns the handshake to its idle, unacknowledged state
    if (clrFlags) begin
      nxt_dps   = FLAG_RST;
      nxt_ack   = FLAG_RST;
      nxt_state = TPP_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_ff <= TPP_IDLE;
      ack_ff   <= FLAG_RST;
      dps_ff   <= FLAG_RST;
    end else if (ce) begin
      state_ff <= nxt_state;
      ack_ff   <= nxt_ack;
      dps_ff   <= nxt_dps;
    end
  end

  // Broadcast flag: reset beats a command arriving in the same cycle
  always_comb begin
    nxt_broadcast_received_flag = broadcast_received_flag_ff;
    if (clrFlags) begin
      nxt_broadcast_received_flag = FLAG_RST;
    end else if (bcastHit) begin
      nxt_broadcast_received_flag = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      broadcast_received_flag_ff <= FLAG_RST;
    end else if (ce) begin
      broadcast_received_flag_ff <= nxt_broadcast_received_flag;
    end
  end

  // User-side outputs: buffer of the message, activity, illegal results
  always_comb begin
    nxt_useB = useBufferB_ff;
    if ((state_ff == TPP_IDLE) && msgStart) begin
      nxt_useB = dps_ff;
    end
    nxt_msgActive = (nxt_state == TPP_MSG);
    nxt_bcIllegal = bcastHit;
    nxt_illResp   = bcastHit & illegalDetectEn;
    nxt_circ2     = link.circ2TrailingZeroCount;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      useBufferB_ff   <= FLAG_RST;
      msgActive_ff    <= FLAG_RST;
      bcastIllegal_ff <= FLAG_RST;
      illegalResp_ff  <= FLAG_RST;
      circ2Count_ff   <= ZN_RST;
    end else if (ce) begin
      useBufferB_ff   <= nxt_useB;
      msgActive_ff    <= nxt_msgActive;
      bcastIllegal_ff <= nxt_bcIllegal;
      illegalResp_ff  <= nxt_illResp;
      circ2Count_ff   <= nxt_circ2;
    end
  end
endmodule : tpp_device

// *** logic/tpp_host.sv ***
// Purpose: Host end: Wishbone registers drive the stop request handshake.
// Assumes: Classic Wishbone slave, 32-bit data, one clock.
// Notes:   Acknowledge field of the control word is never written here.
module tpp_host (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  // Wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [tpp_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [tpp_pkg::SEL_W-1:0] wb_sel_i,
  input  wire logic [tpp_pkg::DAT_W-1:0] wb_dat_i,
  output logic      [tpp_pkg::DAT_W-1:0] wb_dat_o,
  output logic                        wb_ack_o,
  // Status out
  output logic                        irq_ff,
  output logic                        loadPermit_ff,
  // Link to terminal
  tpp_link_if.host                    link
);
  import tpp_pkg::*;

  logic             pingpong_enable_ff, nxt_pingpong_enable;
  logic             stop_ff, nxt_stop;
  logic [ZN_W-1:0]  zn_ff, nxt_zn;
  logic             swRst_ff, nxt_swRst;
  logic [EV_W-1:0]  stat_ff, nxt_stat;
  logic [EV_W-1:0]  ien_ff, nxt_ien;
  logic             ackSeen_ff, nxt_ackSeen;
  logic             bcSeen_ff, nxt_bcSeen;
  logic             busAck_ff, nxt_busAck;
  logic [DAT_W-1:0] rdat_ff, nxt_rdat;
  logic             irqNxt, permitNxt;
  logic             req, wr;
  logic [EV_W-1:0]  ev, clr;
  logic [CW_W-1:0]  cw;

  assign link.pingpongEnable         = pingpong_enable_ff;
  assign link.pingpongStopRequest    = stop_ff;
  assign link.circ2TrailingZeroCount = zn_ff;
  assign link.softwareResetCmd       = swRst_ff;
  assign wb_ack_o = busAck_ff;
  assign wb_dat_o = rdat_ff;

  always_comb begin
    req = wb_cyc_i & wb_stb_i & ~busAck_ff;
    wr  = req & wb_we_i & wb_sel_i[0];
    cw  = '0;
    cw[BIT_PINGPONG_ENABLE]            = pingpong_enable_ff;
    cw[BIT_PINGPONG_STOP_REQUEST]           = stop_ff;
    cw[ZN_LO +: ZN_W]       = zn_ff;
    cw[BIT_ACK]             = link.pingpongAck;
    cw[BIT_BROADCAST_RECEIVED_FLAG]           = link.broadcastReceivedFlag;
    cw[BIT_DPS]             = link.dataPointerSelect;
    ev = '0;
    ev[EV_ACKRISE] = link.pingpongAck & ~ackSeen_ff;
    ev[EV_ACKFALL] = ~link.pingpongAck & ackSeen_ff;
    ev[EV_BROADCAST_RECEIVED_FLAG]   = link.broadcastReceivedFlag & ~bcSeen_ff;
    clr = (wr && wb_adr_i == ADR_CLR) ? wb_dat_i[EV_W-1:0] : '0;
    nxt_pingpong_enable  = pingpong_enable_ff;
    nxt_stop  = stop_ff;
    nxt_zn    = zn_ff;
    nxt_ien   = ien_ff;
    nxt_swRst = wr && wb_adr_i == ADR_CMD && wb_dat_i[CMD_SWRST];
    if (wr && wb_adr_i == ADR_CTRL) begin
      nxt_pingpong_enable = wb_dat_i[BIT_PINGPONG_ENABLE];
      nxt_stop = wb_dat_i[BIT_PINGPONG_STOP_REQUEST];
      nxt_zn   = wb_dat_i[ZN_LO +: ZN_W];
    end
    if (wr && wb_adr_i == ADR_EN) begin
      nxt_ien = wb_dat_i[EV_W-1:0];
    end
    nxt_stat    = (stat_ff & ~clr) | ev;
    nxt_ackSeen = link.pingpongAck;
    nxt_bcSeen  = link.broadcastReceivedFlag;
    nxt_busAck  = req;
    nxt_rdat    = rdat_ff;
    if (req) begin
      case (wb_adr_i)
        ADR_CTRL: nxt_rdat = {{(DAT_W-CW_W){1'b0}}, cw};
        ADR_STAT: nxt_rdat = {{(DAT_W-EV_W){1'b0}}, stat_ff};
        ADR_EN:   nxt_rdat = {{(DAT_W-EV_W){1'b0}}, ien_ff};
        default:  nxt_rdat = '0;
      endcase
    end
    irqNxt    = |(nxt_stat & nxt_ien);
    permitNxt = pingpong_enable_ff & stop_ff & ~link.pingpongAck;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pingpong_enable_ff       <= FLAG_RST;
      stop_ff       <= FLAG_RST;
      zn_ff         <= ZN_RST;
      swRst_ff      <= FLAG_RST;
      stat_ff       <= EV_RST;
      ien_ff        <= EV_RST;
      ackSeen_ff    <= FLAG_RST;
      bcSeen_ff     <= FLAG_RST;
      busAck_ff     <= FLAG_RST;
      rdat_ff       <= '0;
      irq_ff        <= FLAG_RST;
      loadPermit_ff <= FLAG_RST;
    end else if (ce) begin
      pingpong_enable_ff       <= nxt_pingpong_enable;
      stop_ff       <= nxt_stop;
      zn_ff         <= nxt_zn;
      swRst_ff      <= nxt_swRst;
      stat_ff       <= nxt_stat;
      ien_ff        <= nxt_ien;
      ackSeen_ff    <= nxt_ackSeen;
      bcSeen_ff     <= nxt_bcSeen;
      busAck_ff     <= nxt_busAck;
      rdat_ff       <= nxt_rdat;
      irq_ff        <= irqNxt;
      loadPermit_ff <= permitNxt;
    end
  end
endmodule : tpp_host

// *** logic/tpp_link_if.sv ***
// Purpose: Carrier between host end and terminal end.
// Assumes: Both ends on the same clock.
// Notes:   Host owns the request fields, terminal owns the status fields.
interface tpp_link_if;
  logic                   pingpongEnable;
  logic                   pingpongStopRequest;
  logic [tpp_pkg::ZN_W-1:0] circ2TrailingZeroCount;
  logic                   softwareResetCmd;
  logic                   broadcastReceivedFlag;
  logic                   pingpongAck;
  logic                   dataPointerSelect;

  modport host (
    output pingpongEnable,
    output pingpongStopRequest,
    output circ2TrailingZeroCount,
    output softwareResetCmd,
    input  broadcastReceivedFlag,
    input  pingpongAck,
    input  dataPointerSelect
  );

  modport term (
    input  pingpongEnable,
    input  pingpongStopRequest,
    input  circ2TrailingZeroCount,
    input  softwareResetCmd,
    output broadcastReceivedFlag,
    output pingpongAck,
    output dataPointerSelect
  );
endinterface : tpp_link_if

// *** logic/tpp_pkg.sv ***
// Purpose: Shared constants and types for the transmit subaddress
//          ping-pong handshake (terminal end and host end).
// Assumes: One clock, synchronous active-low reset.
// Notes:   Control word bit positions follow the subaddress control word.
package tpp_pkg;
  // Control word layout
  localparam int CW_W      = 16;
  localparam int BIT_PINGPONG_ENABLE  = 2;
  localparam int BIT_PINGPONG_STOP_REQUEST = 3;
  localparam int ZN_LO     = 4;
  localparam int ZN_W      = 4;
  localparam int BIT_ACK   = 8;
  localparam int BIT_BROADCAST_RECEIVED_FLAG = 9;
  localparam int BIT_DPS   = 10;
  // Reset values
  localparam logic            FLAG_RST = 1'b0;
  localparam logic [ZN_W-1:0] ZN_RST   = 4'h0;
  // Pin synchroniser
  localparam int SYNC_N = 3;
  // Wishbone register map
  localparam int              ADR_W    = 8;
  localparam int              DAT_W    = 32;
  localparam int              SEL_W    = 4;
  localparam logic [ADR_W-1:0] ADR_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] ADR_STAT = 8'h04;
  localparam logic [ADR_W-1:0] ADR_CLR  = 8'h08;
  localparam logic [ADR_W-1:0] ADR_EN   = 8'h0c;
  localparam logic [ADR_W-1:0] ADR_CMD  = 8'h10;
  localparam int              CMD_SWRST = 0;
  // Interrupt events
  localparam int EV_W       = 3;
  localparam int EV_ACKRISE = 0;
  localparam int EV_ACKFALL = 1;
  localparam int EV_BROADCAST_RECEIVED_FLAG   = 2;
  localparam logic [EV_W-1:0] EV_RST = 3'h0;
  // Message sequencing
  typedef enum logic [0:0] {TPP_IDLE, TPP_MSG} tpp_msg_state_t;
endpackage : tpp_pkg
